// ===== rtl/sp_cfg_bank.sv
// Configuration bank for serial ports 4 to 6, plus the global index,
// device number and soft reset that steer them, and power control of ports 1 and 2.
// Assumes the bus decoder delivers index/data strobes on this clock.
`timescale 1ns/1ps
module sp_cfg_bank #(
   parameter int OUT_W = sp_cfg_pkg::OUT_W_DEF
) (
   input wire logic REF_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic CFG_MODE_I,
   input wire logic IO_WR_I,
   input wire logic IO_RD_I,
   input wire logic IO_DATA_SEL_I,
   input wire logic [7:0] IO_WDATA_I,
   output logic [7:0] IO_RDATA_O,
   input wire logic [sp_cfg_pkg::NUM_PORTS*OUT_W-1:0] UART_DO_I,
   input wire logic [sp_cfg_pkg::NUM_PORTS-1:0] ALT_SEL_I,
   input wire logic [sp_cfg_pkg::NUM_PORTS*OUT_W-1:0] ALT_DO_I,
   input wire logic [sp_cfg_pkg::NUM_PORTS*OUT_W-1:0] ALT_OE_I,
   output logic [sp_cfg_pkg::NUM_PORTS*OUT_W-1:0] PIN_DO_O,
   output logic [sp_cfg_pkg::NUM_PORTS*OUT_W-1:0] PIN_OE_O,
   output logic [sp_cfg_pkg::NUM_PORTS-1:0] PORT_PWR_O,
   output sp_cfg_pkg::sp_cfg_t [sp_cfg_pkg::NUM_BANKS-1:0] PORT_CFG_O
);
   import sp_cfg_pkg::*;

   // ----------------------------------------------------------------
   // Host access decode
   // ----------------------------------------------------------------
   logic [7:0] index;
   logic [7:0] ldev;
   logic [7:0] power;
   logic [2:0] low_act;
   logic [7:0] next_index;
   logic [7:0] next_ldev;
   logic [7:0] next_power;
   logic [2:0] next_low_act;
   logic [7:0] next_rdata;
   logic [NUM_PORTS-1:0] powered;
   logic [NUM_PORTS-1:0] next_pwr;
   logic wr_index;
   logic wr_data;
   logic rd_data;
   logic soft_clr;
   reg_wr_t bank_wr;
   logic [NUM_BANKS-1:0] bank_sel;
   logic [7:0] bank_rdata [NUM_BANKS];
   sp_cfg_t bank_cfg [NUM_BANKS];

   localparam logic [7:0] BANK_LDN [NUM_BANKS] = '{LDN_SP4, LDN_SP5,
                                                  LDN_SP6};
   localparam logic [7:0] LOW_LDN [3] = '{LDN_SP1, LDN_SP2, LDN_SP3};

   assign wr_index = CFG_MODE_I && IO_WR_I && !IO_DATA_SEL_I;
   assign wr_data = CFG_MODE_I && IO_WR_I && IO_DATA_SEL_I;
   assign rd_data = CFG_MODE_I && IO_RD_I;

   // Soft reset is a write-only pulse; the bit never stores
   assign soft_clr = wr_data && index == IDX_CFG_CTRL
                     && IO_WDATA_I[SOFT_RST_BIT];

   function automatic logic ldev_is(input logic [7:0] cur,
                                    input logic [7:0] num);
      ldev_is = (cur == num);
   endfunction : ldev_is

   function automatic logic [7:0] act_byte(input logic bit0);
      act_byte = {7'h00, bit0};
   endfunction : act_byte

   // ----------------------------------------------------------------
   // Global registers
   // ----------------------------------------------------------------
   always_comb begin
      next_index = index;
      next_ldev = ldev;
      next_power = power;
      next_low_act = low_act;
      if (wr_index) begin
         next_index = IO_WDATA_I;
      end
      if (wr_data) begin
         if (index == IDX_LDEV_NUM) begin
            next_ldev = IO_WDATA_I;
         end else if (index == GLOBAL_POWER_CONTROL_INDEX) begin
            next_power = IO_WDATA_I;
         end else if (index == ACTIVATION_INDEX) begin
            for (int i = 0; i < 3; i++) begin
               if (ldev_is(ldev, LOW_LDN[i])) begin
                  next_low_act[i] = IO_WDATA_I[ACT_BIT];
               end
            end
         end
      end
      if (soft_clr) begin
         next_ldev = REG_RESET_VAL;
         next_power = REG_RESET_VAL;
         next_low_act = 3'h0;
      end
   end

   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         index <= 8'h00;
         ldev <= 8'h00;
         power <= 8'h00;
         low_act <= 3'h0;
      end else begin
         index <= next_index;
         ldev <= next_ldev;
         power <= next_power;
         low_act <= next_low_act;
      end
   end

   // ----------------------------------------------------------------
   // Logical devices for ports 4 to 6
   // ----------------------------------------------------------------
   always_comb begin
      bank_wr.wr = wr_data;
      bank_wr.soft_clr = soft_clr;
      bank_wr.idx = index;
      bank_wr.wdata = IO_WDATA_I;
   end

   genvar g;
   generate
      for (g = 0; g < NUM_BANKS; g++) begin : g_bank
         assign bank_sel[g] = ldev_is(ldev, BANK_LDN[g]);
         sp_ldev_regs u_regs (
            .clk_i(REF_CLK_I),
            .rst_i(SYS_RST_I),
            .sel_i(bank_sel[g]),
            .wr_i(bank_wr),
            .cfg_o(bank_cfg[g]),
            .rdata_o(bank_rdata[g])
         );
         assign PORT_CFG_O[g] = bank_cfg[g];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Powerdown
   // ----------------------------------------------------------------
   always_comb begin
      powered[0] = low_act[0] && power[PWR_SP1_BIT];
      powered[1] = low_act[1] && power[PWR_SP2_BIT];
      // ports 3 to 6 activation only
      powered[2] = low_act[2];
      for (int i = 0; i < NUM_BANKS; i++) begin
         powered[3+i] = bank_cfg[i].activation[ACT_BIT];
      end
      next_pwr = powered;
   end

   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         PORT_PWR_O <= '0;
      end else begin
         PORT_PWR_O <= next_pwr;
      end
   end

   generate
      for (g = 0; g < NUM_PORTS; g++) begin : g_pin
         sp_pin_gate #(.OUT_W(OUT_W)) u_gate (
            .clk_i(REF_CLK_I),
            .rst_i(SYS_RST_I),
            .powered_i(powered[g]),
            .alt_sel_i(ALT_SEL_I[g]),
            .uart_do_i(UART_DO_I[g*OUT_W +: OUT_W]),
            .alt_do_i(ALT_DO_I[g*OUT_W +: OUT_W]),
            .alt_oe_i(ALT_OE_I[g*OUT_W +: OUT_W]),
            .pin_do_o(PIN_DO_O[g*OUT_W +: OUT_W]),
            .pin_oe_o(PIN_OE_O[g*OUT_W +: OUT_W])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata = 8'h00;
      // Closed config space reads zero rather than stale data
      if (rd_data && !IO_DATA_SEL_I) begin
         next_rdata = index;
      end else if (rd_data) begin
         if (index == IDX_LDEV_NUM) begin
            next_rdata = ldev;
         end else if (index == GLOBAL_POWER_CONTROL_INDEX) begin
            next_rdata = power;
         end else if (index == ACTIVATION_INDEX
                      && ldev_is(ldev, LDN_SP1)) begin
            next_rdata = act_byte(low_act[0]);
         end else if (index == ACTIVATION_INDEX
                      && ldev_is(ldev, LDN_SP2)) begin
            next_rdata = act_byte(low_act[1]);
         end else if (index == ACTIVATION_INDEX
                      && ldev_is(ldev, LDN_SP3)) begin
            next_rdata = act_byte(low_act[2]);
         end else begin
            for (int i = 0; i < NUM_BANKS; i++) begin
               if (bank_sel[i]) begin
                  next_rdata = bank_rdata[i];
               end
            end
         end
      end
   end

   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         IO_RDATA_O <= 8'h00;
      end else begin
         IO_RDATA_O <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (SYS_RST_I);

   sequence s_sel_ldev;
      wr_index && IO_WDATA_I == IDX_LDEV_NUM;
   endsequence
   sequence s_write_ldev;
      wr_data && !soft_clr;
   endsequence

   a_ldev_select: assert property (
      s_sel_ldev ##1 s_write_ldev |=> ldev == $past(IO_WDATA_I))
      else $error("device number not taken");
   a_closed_mode: assert property (
      !CFG_MODE_I |=> $stable(index) && $stable(ldev)
         && $stable(power) && IO_RDATA_O == 8'h00)
      else $error("access outside config mode");
   a_sp1_power: assert property (
      !power[PWR_SP1_BIT] |=> !PORT_PWR_O[0])
      else $error("port 1 powered with power bit clear");
   a_sp2_power: assert property (
      low_act[1] && power[PWR_SP2_BIT] |=> PORT_PWR_O[1])
      else $error("port 2 not powered when enabled");
   a_hi_ports_act: assert property (
      PORT_PWR_O[5:3] == {$past(bank_cfg[2].activation[0]),
         $past(bank_cfg[1].activation[0]),
         $past(bank_cfg[0].activation[0])})
      else $error("port 4-6 power not from activation");
   a_soft_clears: assert property (
      soft_clr |=> ldev == 8'h00 && power == 8'h00
         ##1 PORT_PWR_O == '0)
      else $error("soft reset left state behind");
endmodule : sp_cfg_bank

// ===== rtl/sp_cfg_pkg.sv
// Constants and carriers for the extra serial port configuration bank.
// Assumes one host-bus clock and one async reset covering bus and POR.
package sp_cfg_pkg;
   // ----------------------------------------------------------------
   // Register indices
   // ----------------------------------------------------------------
   localparam logic [7:0] ACTIVATION_INDEX = 8'h30;
   localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
   localparam logic [7:0] IDX_BASE_LOW = 8'h61;
   localparam logic [7:0] IDX_IRQ_SELECT = 8'h70;
   localparam logic [7:0] IDX_MODE = 8'hF0;
   localparam logic [7:0] IDX_CFG_CTRL = 8'h02;
   localparam logic [7:0] IDX_LDEV_NUM = 8'h07;
   localparam logic [7:0] GLOBAL_POWER_CONTROL_INDEX = 8'h22;
   // ----------------------------------------------------------------
   // Logical device numbers of the six serial ports
   // ----------------------------------------------------------------
   localparam logic [7:0] LDN_SP1 = 8'h04;
   localparam logic [7:0] LDN_SP2 = 8'h05;
   localparam logic [7:0] LDN_SP3 = 8'h0B;
   localparam logic [7:0] LDN_SP4 = 8'h0C;
   localparam logic [7:0] LDN_SP5 = 8'h0D;
   localparam logic [7:0] LDN_SP6 = 8'h0E;
   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_RESET_VAL = 8'h00;
   localparam int ACT_BIT = 0;
   localparam int SOFT_RST_BIT = 0;
   localparam int PWR_SP1_BIT = 4;
   localparam int PWR_SP2_BIT = 5;
   localparam int NUM_PORTS = 6;
   localparam int NUM_BANKS = 3;
   localparam int OUT_W_DEF = 4;

   typedef struct packed {
      logic [7:0] activation;
      logic [7:0] base_high;
      logic [7:0] base_low;
      logic [7:0] irq_select;
      logic [7:0] mode;
   } sp_cfg_t;

   typedef struct packed {
      logic wr;
      logic soft_clr;
      logic [7:0] idx;
      logic [7:0] wdata;
   } reg_wr_t;
endpackage : sp_cfg_pkg

// ===== rtl/sp_ldev_regs.sv
// One serial port logical device: five byte registers.
// Assumes the caller qualifies writes with config mode and device select.
`timescale 1ns/1ps
module sp_ldev_regs (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sel_i,
   input wire sp_cfg_pkg::reg_wr_t wr_i,
   output sp_cfg_pkg::sp_cfg_t cfg_o,
   output logic [7:0] rdata_o
);
   import sp_cfg_pkg::*;

   sp_cfg_t cfg;
   sp_cfg_t next_cfg;
   logic wr_hit;

   assign wr_hit = wr_i.wr && sel_i;
   assign cfg_o = cfg;

   always_comb begin
      next_cfg = cfg;
      if (wr_hit) begin
         if (wr_i.idx == ACTIVATION_INDEX) begin
            next_cfg.activation = {7'h00, wr_i.wdata[ACT_BIT]};
         end else if (wr_i.idx == IDX_BASE_HIGH) begin
            next_cfg.base_high = wr_i.wdata;
         end else if (wr_i.idx == IDX_BASE_LOW) begin
            next_cfg.base_low = wr_i.wdata;
         end else if (wr_i.idx == IDX_IRQ_SELECT) begin
            next_cfg.irq_select = wr_i.wdata;
         end else if (wr_i.idx == IDX_MODE) begin
            next_cfg.mode = wr_i.wdata;
         end
      end
      if (wr_i.soft_clr) begin
         next_cfg.activation = REG_RESET_VAL;
         next_cfg.base_high = REG_RESET_VAL;
         next_cfg.base_low = REG_RESET_VAL;
         next_cfg.irq_select = REG_RESET_VAL;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg <= '0;
      end else begin
         cfg <= next_cfg;
      end
   end

   always_comb begin
      if (wr_i.idx == ACTIVATION_INDEX) begin
         rdata_o = cfg.activation;
      end else if (wr_i.idx == IDX_BASE_HIGH) begin
         rdata_o = cfg.base_high;
      end else if (wr_i.idx == IDX_BASE_LOW) begin
         rdata_o = cfg.base_low;
      end else if (wr_i.idx == IDX_IRQ_SELECT) begin
         rdata_o = cfg.irq_select;
      end else if (wr_i.idx == IDX_MODE) begin
         rdata_o = cfg.mode;
      end else begin
         rdata_o = 8'h00;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_soft_keeps_mode: assert property (
      wr_i.soft_clr |=> cfg.mode == $past(cfg.mode)
         && cfg.activation == 8'h00 && cfg.base_high == 8'h00)
      else $error("soft reset handled mode or clears wrongly");
   a_act_upper_zero: assert property (
      cfg.activation[7:1] == 7'h00)
      else $error("activation upper bits not zero");
   a_base_write: assert property (
      wr_hit && !wr_i.soft_clr && wr_i.idx == IDX_BASE_LOW
         |=> cfg.base_low == $past(wr_i.wdata))
      else $error("base low write lost");
endmodule : sp_ldev_regs

// ===== rtl/sp_pin_gate.sv
// Output stage of one serial port onto pins shared with another function.
// Assumes alternate function data arrives from logic on the same clock.
`timescale 1ns/1ps
module sp_pin_gate #(
   parameter int OUT_W = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic powered_i,
   input wire logic alt_sel_i,
   input wire logic [OUT_W-1:0] uart_do_i,
   input wire logic [OUT_W-1:0] alt_do_i,
   input wire logic [OUT_W-1:0] alt_oe_i,
   output logic [OUT_W-1:0] pin_do_o,
   output logic [OUT_W-1:0] pin_oe_o
);
   logic [OUT_W-1:0] next_do;
   logic [OUT_W-1:0] next_oe;

   always_comb begin
      if (alt_sel_i) begin
         next_oe = powered_i ? {OUT_W{1'b1}} : {OUT_W{1'b0}};
         next_do = powered_i ? uart_do_i : {OUT_W{1'b0}};
      end else begin
         next_oe = alt_oe_i;
         next_do = alt_do_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_do_o <= '0;
         pin_oe_o <= '0;
      end else begin
         pin_do_o <= next_do;
         pin_oe_o <= next_oe;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_powerdown_hiz: assert property (
      alt_sel_i && !powered_i |=> pin_oe_o == '0)
      else $error("powered-down port still drives");
   a_alt_untouched: assert property (
      !alt_sel_i |=> pin_oe_o == $past(alt_oe_i)
         && pin_do_o == $past(alt_do_i))
      else $error("alternate function disturbed");
endmodule : sp_pin_gate

// ===== verification/sp_cfg_bank_tb.sv
// Self-checking bench for the serial port configuration bank.
// Assumes the host model and the design with its default pin width.
`timescale 1ns/1ps
module sp_cfg_bank_tb;
   import sp_cfg_pkg::*;
   localparam int W = NUM_PORTS*OUT_W_DEF;
   localparam logic [7:0] IDX [5] = '{ACTIVATION_INDEX, IDX_BASE_HIGH,
      IDX_BASE_LOW, IDX_IRQ_SELECT, IDX_MODE};
   localparam logic [7:0] LDN [6] = '{LDN_SP1, LDN_SP2, LDN_SP3, LDN_SP4,
      LDN_SP5, LDN_SP6};
   logic clk, rst, cfg, wr, rd, sel;
   logic [7:0] wd, rdata, q, v, pw22;
   logic [W-1:0] udo, ado, aoe, pdo, poe;
   logic [5:0] asel, pwr, act_e;
   sp_cfg_t [NUM_BANKS-1:0] pcfg;
   logic [7:0] ex [3][5];
   integer seed = 32'h3596503f;
   int mismatches = 0;
   int samples_checked = 0;

   sp_cfg_bank #(.OUT_W(OUT_W_DEF)) uut (.REF_CLK_I(clk), .SYS_RST_I(rst),
      .CFG_MODE_I(cfg), .IO_WR_I(wr), .IO_RD_I(rd), .IO_DATA_SEL_I(sel),
      .IO_WDATA_I(wd), .IO_RDATA_O(rdata), .UART_DO_I(udo),
      .ALT_SEL_I(asel), .ALT_DO_I(ado), .ALT_OE_I(aoe), .PIN_DO_O(pdo),
      .PIN_OE_O(poe), .PORT_PWR_O(pwr), .PORT_CFG_O(pcfg));
   sp_host_model host (.clk_i(clk), .rdata_i(rdata), .cfg_o(cfg),
      .wr_o(wr), .rd_o(rd), .sel_o(sel), .wd_o(wd));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Expectations
   // ----------------------------------------------------------------
   function automatic logic [39:0] cfg_of(int b);
      return {ex[b][0], ex[b][1], ex[b][2], ex[b][3], ex[b][4]};
   endfunction : cfg_of
   // Ports 1,2 also gated by the power register; 3 to 6 are not
   function automatic logic [5:0] pwr_exp(logic [5:0] a, logic [7:0] p);
      return {a[5:2], a[1] & p[PWR_SP2_BIT], a[0] & p[PWR_SP1_BIT]};
   endfunction : pwr_exp
   function automatic logic [2*W-1:0] pin_exp(logic [5:0] pw, s,
                                              logic [W-1:0] u, d, e);
      logic [W-1:0] o, k;
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (s[p]) begin
            k[p*OUT_W_DEF +: OUT_W_DEF] = {OUT_W_DEF{pw[p]}};
            o[p*OUT_W_DEF +: OUT_W_DEF] = pw[p] ?
               u[p*OUT_W_DEF +: OUT_W_DEF] : '0;
         end else begin
            k[p*OUT_W_DEF +: OUT_W_DEF] = e[p*OUT_W_DEF +: OUT_W_DEF];
            o[p*OUT_W_DEF +: OUT_W_DEF] = d[p*OUT_W_DEF +: OUT_W_DEF];
         end
      end
      return {o, k};
   endfunction : pin_exp

   task automatic check(input logic [63:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict

   // Hang guard, far beyond the longest sequence
   initial begin
      #(40000*50);
      mismatches++;
      print_verdict();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {udo, ado, aoe, asel, act_e, pw22} = '0;
      ex = '{default: 8'h00};
      repeat (10) @(negedge clk);
      for (int b = 0; b < 3; b++) check(pcfg[b], '0);
      check({pwr, poe}, '0);
      rst = 1'b0;
      host.set_cfg(1'b1);
      for (int b = 0; b < 3; b++) begin
         host.sel_dev(LDN[b+3]);
         for (int f = 0; f < 5; f++) begin
            v = 8'($random(seed));
            host.wr_reg(IDX[f], v);
            ex[b][f] = (f == 0) ? (v & 8'h01) : v;
         end
      end
      // Read back after all writes, so aliasing between ports shows
      for (int b = 0; b < 3; b++) begin
         host.sel_dev(LDN[b+3]);
         for (int f = 0; f < 5; f++) begin
            host.rd_reg(IDX[f], q);
            check(q, ex[b][f]);
         end
         check(pcfg[b], cfg_of(b));
      end
      @(negedge clk);
      check(rdata, 8'h00);
      host.sel_dev(LDN_SP4);
      host.wr_reg(8'h62, 8'hA5);
      host.rd_reg(8'h62, q);
      check(q, 8'h00);
      host.sel_dev(8'h0F);
      host.wr_reg(IDX_MODE, 8'h5A);
      host.rd_reg(IDX_MODE, q);
      check(q, 8'h00);
      host.sel_dev(LDN_SP4);
      host.set_cfg(1'b0);
      host.wr_reg(IDX_MODE, ~ex[0][4]);
      host.rd_reg(IDX_MODE, q);
      check(q, 8'h00);
      host.set_cfg(1'b1);
      for (int b = 0; b < 3; b++) check(pcfg[b], cfg_of(b));
      // Power and pins; first trial is hand-made: port 2 off by power
      for (int t = 0; t < 10; t++) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            host.sel_dev(LDN[p]);
            v = (t == 0) ? 8'hFF : 8'($random(seed));
            host.wr_reg(ACTIVATION_INDEX, v);
            act_e[p] = v[ACT_BIT];
            if (p > 2) ex[p-3][0] = v & 8'h01;
         end
         pw22 = (t == 0) ? 8'h10 : 8'($random(seed));
         host.wr_reg(GLOBAL_POWER_CONTROL_INDEX, pw22);
         udo = W'($random(seed));
         ado = W'($random(seed));
         aoe = W'($random(seed));
         asel = (t == 0) ? 6'h3F : 6'($random(seed));
         repeat (2) @(negedge clk);
         check(pwr, pwr_exp(act_e, pw22));
         check({pdo, poe}, pin_exp(pwr_exp(act_e, pw22), asel, udo, ado,
            aoe));
      end
      for (int b = 0; b < 3; b++) check(pcfg[b], cfg_of(b));
      // Ports 1 to 3 keep only their activation bit here
      for (int p = 0; p < 3; p++) begin
         host.sel_dev(LDN[p]);
         host.rd_reg(ACTIVATION_INDEX, q);
         check(q, {7'h00, act_e[p]});
      end
      host.wr_reg(IDX_CFG_CTRL, 8'h01);
      repeat (2) @(negedge clk);
      for (int b = 0; b < 3; b++) begin
         for (int f = 0; f < 4; f++) ex[b][f] = 8'h00;
         check(pcfg[b], cfg_of(b));
      end
      check(pwr, 6'h00);
      host.rd_reg(IDX_LDEV_NUM, q);
      check(q, 8'h00);
      host.rd_reg(GLOBAL_POWER_CONTROL_INDEX, q);
      check(q, 8'h00);
      // Index port read returns the selected index
      host.put(1'b0, 1'b1, 1'b0, 8'h00);
      host.idle(q);
      check(q, GLOBAL_POWER_CONTROL_INDEX);
      rst = 1'b1;
      @(negedge clk);
      for (int b = 0; b < 3; b++) check(pcfg[b], '0);
      rst = 1'b0;
      @(negedge clk);
      check(pwr, 6'h00);
      print_verdict();
   end
endmodule : sp_cfg_bank_tb

// ===== verification/sp_host_model.sv
// Host model driving the index/data configuration ports.
// Assumes one clock; all changes are made at its falling edge.
`timescale 1ns/1ps
module sp_host_model (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output logic cfg_o,
   output logic wr_o,
   output logic rd_o,
   output logic sel_o,
   output logic [7:0] wd_o
);
   import sp_cfg_pkg::*;
   initial begin
      cfg_o = 1'b0;
      wr_o = 1'b0;
      rd_o = 1'b0;
      sel_o = 1'b0;
      wd_o = 8'h00;
   end
   task automatic set_cfg(input logic v);
      @(negedge clk_i);
      cfg_o = v;
   endtask : set_cfg
   task automatic put(input logic w, r, s, input logic [7:0] d);
      @(negedge clk_i);
      wr_o = w;
      rd_o = r;
      sel_o = s;
      wd_o = d;
   endtask : put
   // Released data shows the inverse, never a stale copy
   task automatic idle(output logic [7:0] q);
      @(negedge clk_i);
      q = rdata_i;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wd_o = ~wd_o;
   endtask : idle
   task automatic wr_reg(input logic [7:0] i, v);
      logic [7:0] q;
      put(1'b1, 1'b0, 1'b0, i);
      put(1'b1, 1'b0, 1'b1, v);
      idle(q);
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] i, output logic [7:0] q);
      put(1'b1, 1'b0, 1'b0, i);
      put(1'b0, 1'b1, 1'b1, ~i);
      idle(q);
   endtask : rd_reg
   task automatic sel_dev(input logic [7:0] n);
      wr_reg(IDX_LDEV_NUM, n);
   endtask : sel_dev
endmodule : sp_host_model
